// ==== rtl/async_serial_sync.sv ====
/*
 * Package of shared constants for the terminal serial interface, and the
 * three-stage pin synchroniser used on every line that enters from the terminal.
 * Assumes a single 100 MHz clock and an asynchronous active-low reset.
 */

// ************************************************************
// Shared constants
// ************************************************************
package async_serial_pkg;
	// Device codes: transmitter 11 octal, receiver 10 octal
	localparam logic [5:0] TX_DEV_CODE = 6'h09;
	localparam logic [5:0] RX_DEV_CODE = 6'h08;
	// Priority mask bits, numbered with bit 0 as the most significant
	localparam int TX_MASK_BIT = 15;
	localparam int RX_MASK_BIT = 14;
	// Character field in the accumulator, bits 8 to 15 (bit 8 is the char MSB)
	localparam int CHAR_FIRST_BIT = 8;
	localparam int CHAR_BITS = 8;
	// Line timing
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_DEFAULT = 9600;
	localparam int BIT_TIME_NS = 1_000_000_000 / BAUD_DEFAULT;
	localparam int BIT_CYCLES_DEFAULT = BIT_TIME_NS / (1_000_000_000 / CLK_HZ);
	localparam int SLOW_BAUD_LIMIT = 110;
	localparam int STOP_BITS_SLOW = 2;
	localparam int STOP_BITS_FAST = 1;
	localparam int STOP_BITS_DEFAULT =
		(BAUD_DEFAULT <= SLOW_BAUD_LIMIT) ? STOP_BITS_SLOW : STOP_BITS_FAST;
	// Line levels
	localparam logic LINE_MARK = 1'b1;
	localparam logic LINE_SPACE = 1'b0;
	// Transfer kind and flag function of an I/O command
	typedef enum logic [1:0] {
		XFER_NONE = 2'h0,
		XFER_READ_A = 2'h1,
		XFER_WRITE_A = 2'h2
	} xfer_t;
	typedef enum logic [1:0] {
		FN_NONE = 2'h0,
		FN_START = 2'h1,
		FN_CLEAR = 2'h2,
		FN_PULSE = 2'h3
	} func_t;
	// Serial frame states, Gray coded along idle-start-data-stop
	typedef enum logic [1:0] {
		FR_IDLE = 2'h0,
		FR_START = 2'h1,
		FR_DATA = 2'h3,
		FR_STOP = 2'h2
	} frame_t;
endpackage : async_serial_pkg

`timescale 1ns/1ps

// ************************************************************
// Three-stage pin synchroniser
// ************************************************************
module pin_sync3 #(
	parameter logic RESET_LEVEL = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Pin and result
	input wire logic pin,
	output logic level
);
	logic ff1_reg;
	logic ff2_reg;
	logic ff3_reg;
	logic level_reg;
	wire agree = (ff2_reg == ff3_reg);

	// Only the second stage reads the first; a change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ff1_reg <= RESET_LEVEL;
			ff2_reg <= RESET_LEVEL;
			ff3_reg <= RESET_LEVEL;
			level_reg <= RESET_LEVEL;
		end else begin
			ff1_reg <= pin;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
			if (agree) begin
				level_reg <= ff3_reg;
			end
		end
	end

	assign level = level_reg;
endmodule : pin_sync3

// ==== rtl/async_terminal_serial_interface.sv ====
/*
 * Programmed-I/O asynchronous terminal interface: a transmitter and a receiver
 * that answer as two devices on the processor I/O command port.
 * Assumes the CPU presents one command per io_strobe pulse, decoded here by
 * device code; accumulator and mask words use bit 0 as the most significant.
 */
`timescale 1ns/1ps

module async_terminal_serial_interface #(
	parameter int BIT_CYCLES = async_serial_pkg::BIT_CYCLES_DEFAULT,
	parameter int STOP_BITS = async_serial_pkg::STOP_BITS_DEFAULT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Processor I/O command port
	input wire logic io_strobe,
	input wire logic [5:0] io_device,
	input wire async_serial_pkg::xfer_t io_xfer,
	input wire async_serial_pkg::func_t io_func,
	input wire logic [0:15] acc_in,
	output logic [0:15] acc_out,
	output logic acc_valid,
	// System-wide control commands
	input wire logic io_reset_cmd,
	input wire logic priority_mask_write_cmd,
	input wire logic [0:15] mask_in,
	input wire logic interrupt_acknowledge_cmd,
	output logic intr_req,
	// Device flags for skip tests
	output logic tx_busy,
	output logic tx_done,
	output logic rx_busy,
	output logic rx_done,
	// Terminal line
	input wire logic rxd,
	input wire logic cts,
	output logic txd
);
	localparam int TW = $clog2(BIT_CYCLES + 1);
	localparam logic [TW-1:0] BIT_LOAD = TW'(BIT_CYCLES - 1);
	localparam logic [TW-1:0] HALF_LOAD = TW'(BIT_CYCLES / 2 - 1);
	localparam logic [1:0] STOP_LOAD = 2'(STOP_BITS - 1);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic rxd_s;
	logic cts_s;
	pin_sync3 #(.RESET_LEVEL(async_serial_pkg::LINE_MARK)) u_rxd_sync (
		.clk(clk), .rst_b(rst_b), .pin(rxd), .level(rxd_s));
	pin_sync3 #(.RESET_LEVEL(1'b0)) u_cts_sync (
		.clk(clk), .rst_b(rst_b), .pin(cts), .level(cts_s));

	// ************************************************************
	// Command decode
	// ************************************************************
	// Two separate device selects on one command port
	wire tx_sel = io_strobe && (io_device == async_serial_pkg::TX_DEV_CODE);
	wire rx_sel = io_strobe && (io_device == async_serial_pkg::RX_DEV_CODE);
	wire fn_start = (io_func == async_serial_pkg::FN_START);
	wire fn_clear = (io_func == async_serial_pkg::FN_CLEAR);
	wire write_char_cmd = tx_sel && (io_xfer == async_serial_pkg::XFER_WRITE_A);
	wire write_char_start_cmd = write_char_cmd && fn_start;
	wire read_char_cmd = rx_sel && (io_xfer == async_serial_pkg::XFER_READ_A);
	wire read_char_restart_cmd = read_char_cmd && fn_start;
	wire read_char_stop_cmd = read_char_cmd && fn_clear;
	wire no_transfer_start_cmd = rx_sel && (io_xfer == async_serial_pkg::XFER_NONE) && fn_start;
	// Any command to a device may start or clear its flags
	wire tx_start = tx_sel && fn_start;
	wire tx_clear = tx_sel && fn_clear;
	wire rx_start = rx_sel && fn_start;
	wire rx_clear = rx_sel && fn_clear;
	wire [7:0] acc_char = acc_in[8:15];

	// ************************************************************
	// Registers
	// ************************************************************
	logic tx_busy_reg, tx_done_reg, rx_busy_reg, rx_done_reg;
	logic tx_dis_reg, rx_dis_reg;
	logic [7:0] tx_hold_reg, rx_hold_reg;
	logic tx_full_reg;
	async_serial_pkg::frame_t tx_state_reg, tx_state_next;
	async_serial_pkg::frame_t rx_state_reg, rx_state_next;
	logic [TW-1:0] tx_tmr_reg, rx_tmr_reg;
	logic [2:0] tx_idx_reg, rx_idx_reg;
	logic [1:0] tx_stop_reg;
	logic [7:0] tx_sh_reg, rx_sh_reg;
	logic txd_reg;
	logic [0:15] acc_out_reg;
	logic acc_valid_reg;

	// ************************************************************
	// Transmitter
	// ************************************************************
	// Hand-off waits one cycle if a transmitter command is in flight, so no flag race arises
	wire tx_tick = (tx_tmr_reg == '0);
	wire tx_load = (tx_state_reg == async_serial_pkg::FR_IDLE) && tx_full_reg && tx_busy_reg
		&& cts_s && !tx_sel && !io_reset_cmd;
	wire tx_last_data = (tx_idx_reg == 3'h7);
	wire tx_last_stop = (tx_stop_reg == 2'h0);

	// Frame sequencer: start, eight data bits LSB first, stop bits
	always_comb begin
		tx_state_next = tx_state_reg;
		case (tx_state_reg)
			async_serial_pkg::FR_IDLE: if (tx_load) tx_state_next = async_serial_pkg::FR_START;
			async_serial_pkg::FR_START: if (tx_tick) tx_state_next = async_serial_pkg::FR_DATA;
			async_serial_pkg::FR_DATA: begin
				if (tx_tick && tx_last_data) tx_state_next = async_serial_pkg::FR_STOP;
			end
			async_serial_pkg::FR_STOP: begin
				if (tx_tick && tx_last_stop) tx_state_next = async_serial_pkg::FR_IDLE;
			end
			default: tx_state_next = async_serial_pkg::FR_IDLE;
		endcase
	end

	// Shifter and bit timer; I/O reset abandons a frame in progress
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_state_reg <= async_serial_pkg::FR_IDLE;
			tx_tmr_reg <= '0;
			tx_idx_reg <= 3'h0;
			tx_stop_reg <= 2'h0;
			tx_sh_reg <= 8'h00;
			txd_reg <= async_serial_pkg::LINE_MARK;
		end else if (io_reset_cmd) begin
			tx_state_reg <= async_serial_pkg::FR_IDLE;
			txd_reg <= async_serial_pkg::LINE_MARK;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_tmr_reg <= (tx_load || tx_tick) ? BIT_LOAD : tx_tmr_reg - 1'b1;
			if (tx_load) begin
				tx_sh_reg <= tx_hold_reg;
				tx_idx_reg <= 3'h0;
				tx_stop_reg <= STOP_LOAD;
			end else if (tx_tick && tx_state_reg == async_serial_pkg::FR_DATA) begin
				tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
				tx_idx_reg <= tx_idx_reg + 3'h1;
			end else if (tx_tick && tx_state_reg == async_serial_pkg::FR_STOP) begin
				tx_stop_reg <= tx_stop_reg - 2'h1;
			end
			// Line idles at mark; start bit is space, data bits follow the shifter LSB, stop bits are mark
			case (tx_state_reg)
				async_serial_pkg::FR_START: txd_reg <= async_serial_pkg::LINE_SPACE;
				async_serial_pkg::FR_DATA: txd_reg <= tx_sh_reg[0];
				default: txd_reg <= async_serial_pkg::LINE_MARK;
			endcase
		end
	end

	// ************************************************************
	// Receiver
	// ************************************************************
	// Start edge is rechecked at mid-bit so a glitch does not start a frame
	wire rx_tick = (rx_tmr_reg == '0);
	wire rx_complete = (rx_state_reg == async_serial_pkg::FR_STOP) && rx_tick
		&& (rxd_s == async_serial_pkg::LINE_MARK) && !io_reset_cmd;

	always_comb begin
		rx_state_next = rx_state_reg;
		case (rx_state_reg)
			async_serial_pkg::FR_IDLE: begin
				if (rxd_s == async_serial_pkg::LINE_SPACE) rx_state_next = async_serial_pkg::FR_START;
			end
			async_serial_pkg::FR_START: begin
				if (rx_tick) begin
					rx_state_next = (rxd_s == async_serial_pkg::LINE_SPACE) ?
						async_serial_pkg::FR_DATA : async_serial_pkg::FR_IDLE;
				end
			end
			async_serial_pkg::FR_DATA: begin
				if (rx_tick && rx_idx_reg == 3'h7) rx_state_next = async_serial_pkg::FR_STOP;
			end
			async_serial_pkg::FR_STOP: if (rx_tick) rx_state_next = async_serial_pkg::FR_IDLE;
			default: rx_state_next = async_serial_pkg::FR_IDLE;
		endcase
	end

	// Assembly runs whether or not the receiver is armed; a bad stop bit drops the character
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_state_reg <= async_serial_pkg::FR_IDLE;
			rx_tmr_reg <= '0;
			rx_idx_reg <= 3'h0;
			rx_sh_reg <= 8'h00;
		end else if (io_reset_cmd) begin
			rx_state_reg <= async_serial_pkg::FR_IDLE;
		end else begin
			rx_state_reg <= rx_state_next;
			if (rx_state_reg == async_serial_pkg::FR_IDLE) begin
				rx_tmr_reg <= HALF_LOAD;
				rx_idx_reg <= 3'h0;
			end else begin
				rx_tmr_reg <= rx_tick ? BIT_LOAD : rx_tmr_reg - 1'b1;
			end
			if (rx_tick && rx_state_reg == async_serial_pkg::FR_DATA) begin
				rx_sh_reg <= {rxd_s, rx_sh_reg[7:1]};
				rx_idx_reg <= rx_idx_reg + 3'h1;
			end
		end
	end

	// ************************************************************
	// Holding registers, flags and mask
	// ************************************************************
	// Receiver done set wins over a software clear in the same cycle; any transmitter command blocks the hand-off, so its clear wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_busy_reg <= 1'b0;
			tx_done_reg <= 1'b0;
			rx_busy_reg <= 1'b0;
			rx_done_reg <= 1'b0;
			tx_dis_reg <= 1'b0;
			rx_dis_reg <= 1'b0;
			tx_full_reg <= 1'b0;
			tx_hold_reg <= 8'h00;
			rx_hold_reg <= 8'h00;
		end else if (io_reset_cmd) begin
			tx_busy_reg <= 1'b0;
			tx_done_reg <= 1'b0;
			rx_busy_reg <= 1'b0;
			rx_done_reg <= 1'b0;
			tx_dis_reg <= 1'b0;
			rx_dis_reg <= 1'b0;
			tx_full_reg <= 1'b0;
		end else begin
			if (write_char_cmd) begin
				tx_hold_reg <= acc_char;
			end
			tx_full_reg <= write_char_cmd || (tx_full_reg && !tx_load);
			// Transmitter: start arms, clear stops, hand-off completes
			if (tx_load) begin
				tx_busy_reg <= 1'b0;
				tx_done_reg <= 1'b1;
			end else if (tx_start) begin
				tx_busy_reg <= 1'b1;
				tx_done_reg <= 1'b0;
			end else if (tx_clear) begin
				tx_busy_reg <= 1'b0;
				tx_done_reg <= 1'b0;
			end
			// Each new character overwrites the last; no overrun guard
			if (rx_complete) begin
				rx_hold_reg <= rx_sh_reg;
			end
			rx_busy_reg <= rx_start || (rx_busy_reg && !rx_clear && !rx_complete);
			rx_done_reg <= rx_complete || (rx_done_reg && !rx_start && !rx_clear);
			if (priority_mask_write_cmd) begin
				tx_dis_reg <= mask_in[async_serial_pkg::TX_MASK_BIT];
				rx_dis_reg <= mask_in[async_serial_pkg::RX_MASK_BIT];
			end
		end
	end

	// ************************************************************
	// Requests and answers to the processor
	// ************************************************************
	// Receiver answers acknowledge first: its character is the one that can be lost
	wire rx_req = rx_done_reg && !rx_dis_reg;
	wire tx_req = tx_done_reg && !tx_dis_reg;
	wire [5:0] ack_code = rx_req ? async_serial_pkg::RX_DEV_CODE : async_serial_pkg::TX_DEV_CODE;
	wire ack_answer = interrupt_acknowledge_cmd && (rx_req || tx_req);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_out_reg <= 16'h0000;
			acc_valid_reg <= 1'b0;
		end else begin
			acc_valid_reg <= read_char_cmd || ack_answer;
			if (read_char_cmd) begin
				acc_out_reg <= {8'h00, rx_hold_reg};
			end else if (ack_answer) begin
				acc_out_reg <= {10'h000, ack_code};
			end
		end
	end

	assign intr_req = rx_req || tx_req;
	assign acc_out = acc_out_reg;
	assign acc_valid = acc_valid_reg;
	assign tx_busy = tx_busy_reg;
	assign tx_done = tx_done_reg;
	assign rx_busy = rx_busy_reg;
	assign rx_done = rx_done_reg;
	assign txd = txd_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	masked_quiet_a: assert property (tx_dis_reg && rx_dis_reg |-> !intr_req)
		else $error("Request presented while both devices disabled");
	mask_write_a: assert property (priority_mask_write_cmd && !io_reset_cmd
		&& mask_in[15] && mask_in[14] |=> !intr_req)
		else $error("Mask write did not suppress requests");
	rx_arm_a: assert property (no_transfer_start_cmd && !rx_complete && !io_reset_cmd
		|=> rx_busy && !rx_done)
		else $error("Receiver start did not arm");
	rx_capture_a: assert property (rx_complete |=> rx_done && rx_hold_reg == $past(rx_sh_reg))
		else $error("Completed character not held");
	read_char_a: assert property (read_char_cmd && !io_reset_cmd
		|=> acc_valid && acc_out[8:15] == $past(rx_hold_reg) && acc_out[0:7] == 8'h00)
		else $error("Read character returned wrong value");
	read_stop_a: assert property (read_char_stop_cmd && !rx_complete && !io_reset_cmd
		|=> !rx_busy && !rx_done)
		else $error("Read with clear left receiver flags set");
	tx_write_a: assert property (write_char_start_cmd && !io_reset_cmd
		|=> tx_busy && !tx_done && tx_hold_reg == $past(acc_char))
		else $error("Write with start mishandled");
	cts_wait_a: assert property (tx_state_reg == async_serial_pkg::FR_IDLE && !cts_s
		|=> tx_state_reg == async_serial_pkg::FR_IDLE)
		else $error("Frame began without clear to send");
	start_bit_a: assert property (tx_load |-> ##2 !txd ##1 !txd)
		else $error("Start bit missing after hand-off");
	io_reset_a: assert property (io_reset_cmd |=> !tx_busy && !tx_done && !rx_busy && !rx_done
		&& !tx_dis_reg && !rx_dis_reg && txd)
		else $error("I/O reset left state behind");
	ack_code_a: assert property (interrupt_acknowledge_cmd && rx_req
		|=> acc_valid && acc_out[10:15] == async_serial_pkg::RX_DEV_CODE)
		else $error("Acknowledge gave wrong device code");

	char_sent_c: cover property (tx_load ##2 !txd);
	char_recv_c: cover property (rx_complete ##1 rx_done);
	duplex_c: cover property (tx_state_reg == async_serial_pkg::FR_DATA
		&& rx_state_reg == async_serial_pkg::FR_DATA);
	masked_done_c: cover property (rx_done && rx_dis_reg ##1 !rx_dis_reg);
endmodule : async_terminal_serial_interface

// ==== dv/terminal_model.sv ====
/*
 * Behavioural terminal on the far side of the serial line: it sends frames
 * on rxd, decodes frames seen on txd and drives Clear To Send.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps

// ************************************************************
// Serial terminal model
// ************************************************************
module terminal_model #(
	parameter int BIT_CYCLES = 16,
	parameter int STOP_BITS = 2
) (
	// Clock
	input wire logic clk,
	// Line to and from the interface
	input wire logic txd,
	output logic rxd,
	output logic cts
);
	logic [7:0] rx_byte;
	logic stop_ok;
	int rx_count;

	// Line rests at mark, so a released line never reads as a start bit
	initial begin
		rxd = 1'b1;
		cts = 1'b1;
		rx_byte = 8'h00;
		stop_ok = 1'b0;
		rx_count = 0;
	end

	// Clear To Send gates the start of each outgoing frame
	task automatic set_cts(input logic on);
		cts = on;
	endtask : set_cts

	// One start bit, eight data bits LSB first, then the stop bits
	task automatic send_char(input logic [7:0] c);
		rxd = 1'b0;
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clk);
			#1 rxd = c[i];
		end
		repeat (BIT_CYCLES) @(posedge clk);
		#1 rxd = 1'b1;
		repeat (BIT_CYCLES * STOP_BITS) @(posedge clk);
		#1;
	endtask : send_char

	// Decode frames mid-bit; a short start pulse is taken as noise
	always begin
		@(negedge txd);
		repeat (BIT_CYCLES / 2) @(posedge clk);
		if (txd == 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge clk);
				rx_byte[i] = txd;
			end
			stop_ok = 1'b1;
			for (int i = 0; i < STOP_BITS; i++) begin
				repeat (BIT_CYCLES) @(posedge clk);
				stop_ok = stop_ok & txd;
			end
			rx_count++;
		end
	end
endmodule : terminal_model

// ==== dv/async_terminal_serial_interface_tb_top.sv ====
/*
 * Self-checking bench for the terminal serial interface: command port
 * traffic, mask and acknowledge, with the terminal model on the line.
 * Assumes the design package is compiled first; short bit time used.
 */
`timescale 1ns/1ps

module async_terminal_serial_interface_tb_top;
	localparam int BITC = 16;
	localparam int STOPS = 2;
	logic clk;
	logic rst_b;
	logic io_strobe;
	logic [5:0] io_device;
	async_serial_pkg::xfer_t io_xfer;
	async_serial_pkg::func_t io_func;
	logic [0:15] acc_in;
	logic [0:15] acc_out;
	logic acc_valid;
	logic io_reset_cmd;
	logic priority_mask_write_cmd;
	logic [0:15] mask_in;
	logic interrupt_acknowledge_cmd;
	logic intr_req, tx_busy, tx_done, rx_busy, rx_done, rxd, cts, txd;
	int n_errors;
	int num_checks;
	int seed;
	int cnt;
	logic [7:0] tx_c, rx_c;

	async_terminal_serial_interface #(.BIT_CYCLES(BITC), .STOP_BITS(STOPS)) dut_u (
		.clk(clk), .rst_b(rst_b), .io_strobe(io_strobe), .io_device(io_device),
		.io_xfer(io_xfer), .io_func(io_func), .acc_in(acc_in), .acc_out(acc_out),
		.acc_valid(acc_valid), .io_reset_cmd(io_reset_cmd),
		.priority_mask_write_cmd(priority_mask_write_cmd), .mask_in(mask_in),
		.interrupt_acknowledge_cmd(interrupt_acknowledge_cmd), .intr_req(intr_req),
		.tx_busy(tx_busy), .tx_done(tx_done), .rx_busy(rx_busy), .rx_done(rx_done),
		.rxd(rxd), .cts(cts), .txd(txd));

	terminal_model #(.BIT_CYCLES(BITC), .STOP_BITS(STOPS)) term_u (
		.clk(clk), .txd(txd), .rxd(rxd), .cts(cts));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Expected answer words
	function automatic logic [15:0] exp_read(input logic [7:0] c);
		return {8'h00, c};
	endfunction : exp_read
	function automatic logic [15:0] exp_code(input logic [5:0] d);
		return {10'h000, d};
	endfunction : exp_code
	function automatic logic [15:0] flags_now();
		return {12'h000, tx_busy, tx_done, rx_busy, rx_done};
	endfunction : flags_now

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR time=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("Counts: %0d checks, %0d mismatches", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	// One command, held for exactly one taking edge
	task automatic cmd(input logic [5:0] dev, input async_serial_pkg::xfer_t x,
		input async_serial_pkg::func_t f, input logic [7:0] c);
		io_device = dev;
		io_xfer = x;
		io_func = f;
		acc_in = {8'h00, c};
		io_strobe = 1'b1;
		@(posedge clk);
		#1 io_strobe = 1'b0;
	endtask : cmd

	// System pulses: 0 I/O reset, 1 mask write, 2 acknowledge
	task automatic ctl(input int which, input logic [15:0] m);
		io_reset_cmd = (which == 0);
		priority_mask_write_cmd = (which == 1);
		interrupt_acknowledge_cmd = (which == 2);
		mask_in = m;
		@(posedge clk);
		#1 io_reset_cmd = 1'b0;
		priority_mask_write_cmd = 1'b0;
		interrupt_acknowledge_cmd = 1'b0;
	endtask : ctl

	// Bounded wait: 0 rx done, 1 tx done, 2 terminal count, 3 tx busy clear
	task automatic wait_for(input int sel, input int n);
		int k;
		for (k = 0; k < 2000; k++) begin
			if ((sel == 0 && rx_done === 1'b1) || (sel == 1 && tx_done === 1'b1) ||
				(sel == 2 && term_u.rx_count == n) || (sel == 3 && tx_busy === 1'b0)) begin
				break;
			end
			@(posedge clk);
			#1;
		end
		if (k == 2000) begin
			n_errors++;
			$display("ERROR time=%0t wait expired seen=%h expected=%h", $time, sel, n);
			finish_test();
		end
	endtask : wait_for

	// Main sequence
	initial begin
		seed = 32'h0331_9935;
		n_errors = 0;
		num_checks = 0;
		cnt = 0;
		io_strobe = 1'b0;
		io_device = 6'h00;
		io_xfer = async_serial_pkg::XFER_NONE;
		io_func = async_serial_pkg::FN_NONE;
		acc_in = 16'h0000;
		io_reset_cmd = 1'b0;
		priority_mask_write_cmd = 1'b0;
		mask_in = 16'h0000;
		interrupt_acknowledge_cmd = 1'b0;
		rst_b = 1'b0;
		repeat (5) @(posedge clk);
		#1 rst_b = 1'b1;
		check(flags_now(), 16'h0000);
		check(16'({txd, intr_req}), 16'h0002);
		cmd(async_serial_pkg::RX_DEV_CODE, async_serial_pkg::XFER_NONE,
			async_serial_pkg::FN_START, 8'h00);
		check(flags_now(), 16'h0002);
		$display("Test power-up and arm finished");
		// Both directions at once, corner characters first
		for (int i = 0; i < 6; i++) begin
			tx_c = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($random(seed));
			rx_c = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($random(seed));
			wait_for(3, 0);
			fork
				term_u.send_char(rx_c);
				cmd(async_serial_pkg::TX_DEV_CODE, async_serial_pkg::XFER_WRITE_A,
					async_serial_pkg::FN_START, tx_c);
			join
			wait_for(0, 0);
			check(16'({rx_done, intr_req}), 16'h0003);
			cnt++;
			wait_for(2, cnt);
			check(16'({term_u.rx_byte, term_u.stop_ok}), {7'h00, tx_c, 1'b1});
			check(flags_now(), 16'h0005);
			cmd(async_serial_pkg::RX_DEV_CODE, async_serial_pkg::XFER_READ_A,
				async_serial_pkg::FN_START, 8'h00);
			check(acc_out, exp_read(rx_c));
			check(16'({acc_valid, rx_busy, rx_done}), 16'h0006);
		end
		$display("Test full duplex finished");
		// Two characters unread: the second one replaces the first
		tx_c = 8'($random(seed));
		rx_c = 8'($random(seed));
		term_u.send_char(tx_c);
		term_u.send_char(rx_c);
		wait_for(0, 0);
		cmd(async_serial_pkg::RX_DEV_CODE, async_serial_pkg::XFER_READ_A,
			async_serial_pkg::FN_CLEAR, 8'h00);
		check(acc_out, exp_read(rx_c));
		check(flags_now(), 16'h0004);
		$display("Test overwrite and stop finished");
		// Character held back while the terminal withholds Clear To Send
		term_u.set_cts(1'b0);
		// Let the withdrawn Clear To Send pass the pin synchroniser first
		repeat (6) @(posedge clk);
		#1;
		tx_c = 8'($random(seed));
		cmd(async_serial_pkg::TX_DEV_CODE, async_serial_pkg::XFER_WRITE_A,
			async_serial_pkg::FN_START, tx_c);
		repeat (40) @(posedge clk);
		#1 check(16'({tx_busy, tx_done, txd}), 16'h0005);
		term_u.set_cts(1'b1);
		cnt++;
		wait_for(2, cnt);
		check(16'(term_u.rx_byte), 16'(tx_c));
		$display("Test clear to send finished");
		// Mask and acknowledge with both devices done
		term_u.send_char(8'($random(seed)));
		wait_for(0, 0);
		ctl(1, 16'h0003);
		check(16'(intr_req), 16'h0000);
		ctl(1, 16'h0001);
		ctl(2, 16'h0000);
		check(acc_out, exp_code(async_serial_pkg::RX_DEV_CODE));
		ctl(1, 16'h0002);
		ctl(2, 16'h0000);
		check(acc_out, exp_code(async_serial_pkg::TX_DEV_CODE));
		ctl(1, 16'h0000);
		cmd(async_serial_pkg::RX_DEV_CODE, async_serial_pkg::XFER_READ_A,
			async_serial_pkg::FN_CLEAR, 8'h00);
		ctl(2, 16'h0000);
		check(acc_out, exp_code(async_serial_pkg::TX_DEV_CODE));
		cmd(async_serial_pkg::TX_DEV_CODE, async_serial_pkg::XFER_NONE,
			async_serial_pkg::FN_CLEAR, 8'h00);
		ctl(2, 16'h0000);
		check(16'({intr_req, acc_valid}), 16'h0000);
		$display("Test mask and acknowledge finished");
		// I/O reset drops flags and mask; unknown device code is ignored
		term_u.set_cts(1'b0);
		ctl(1, 16'h0003);
		cmd(async_serial_pkg::RX_DEV_CODE, async_serial_pkg::XFER_NONE,
			async_serial_pkg::FN_START, 8'h00);
		cmd(async_serial_pkg::TX_DEV_CODE, async_serial_pkg::XFER_WRITE_A,
			async_serial_pkg::FN_START, 8'h5a);
		ctl(0, 16'h0000);
		check(16'({flags_now(), intr_req, txd}), 16'h0001);
		term_u.set_cts(1'b1);
		cmd(6'h0a, async_serial_pkg::XFER_WRITE_A, async_serial_pkg::FN_START, 8'h33);
		check(flags_now(), 16'h0000);
		cmd(async_serial_pkg::TX_DEV_CODE, async_serial_pkg::XFER_WRITE_A,
			async_serial_pkg::FN_START, 8'hc3);
		wait_for(1, 0);
		check(16'(intr_req), 16'h0001);
		cnt++;
		wait_for(2, cnt);
		check(16'(term_u.rx_byte), 16'h00c3);
		$display("Test io reset finished");
		finish_test();
	end
endmodule : async_terminal_serial_interface_tb_top
